// ### hw/operand_former.sv
// Forms the write source: a general register, or a rotated 8-bit immediate.
// Assumes purely combinational use within one core cycle.
`default_nettype none
module operand_former (
   operand_if.former op
);
   logic [63:0] doubled;
   logic [4:0] amount;
   always_comb begin
      amount = {op.rotate, 1'b0};
      doubled = {32'h00000000, 24'h000000, op.imm8} << (6'd32 - {1'b0, amount});
      doubled = doubled | ({32'h00000000, 24'h000000, op.imm8} >> amount);
      if (op.useImm) begin
         op.operand = doubled[31:0];
      end else begin
         op.operand = op.regValue;
      end
   end
endmodule : operand_former
`default_nettype wire

// ### hw/operand_if.sv
// Carries the decoded source operand into the operand former.
// Assumes both ends are inside the status-word transfer unit.
`default_nettype none
interface operand_if;
   logic useImm;
   logic [7:0] imm8;
   logic [3:0] rotate;
   logic [31:0] regValue;
   logic [31:0] operand;
   modport user (output useImm, output imm8, output rotate, output regValue, input operand);
   modport former (input useImm, input imm8, input rotate, input regValue, output operand);
endinterface : operand_if
`default_nettype wire

// ### hw/status_register_transfer.sv
// Executes the read-status and write-status instructions of the core.
// Assumes the decode stage holds an instruction stable while busy is high.
`default_nettype none
// Operation
// - An instruction whose condition fails completes with no effect.
// - A read copies the whole current or saved status word into the destination register.
// - A write updates only the status-word bytes chosen by its field mask.
// - An immediate is the 8-bit field zero-extended and rotated right by twice rotate.
// - In User mode only the condition flags of the current status word change.
// - The saved status word used is the bank of the mode at execution time.
// - Only flags, two interrupt disables and the mode field exist; the rest read zero.
// - Writes of any value to bits 27 to 24 are accepted without fault.
// - A privileged write to the mode field changes the processor mode.
// - A read completes in one cycle.
// - A write whose condition passes takes one cycle for flags only or a saved word, else three cycles; a failed one takes one.
// - Field-mask bits 0 to 3 select control, extension, status and flags bytes.
module status_register_transfer (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic instValid,
   input wire logic [3:0] instCond,
   input wire logic isWrite,
   input wire logic useSaved,
   input wire logic [3:0] fieldMask,
   input wire logic useImm,
   input wire logic [7:0] imm8,
   input wire logic [3:0] rotate,
   input wire logic [3:0] regIndex,
   input wire logic [31:0] sourceRegValue,
   output logic busy,
   output logic done,
   output logic destWrite,
   output logic [3:0] destIndex,
   output logic [31:0] destData,
   output logic [31:0] currentStatus,
   output logic [4:0] processorMode
);
   typedef enum {IDLE, WAIT_LONG} state_e;
   state_e state;
   logic [1:0] waitCount;
   logic [31:0] current_status_word;
   logic [31:0] savedBank [status_xfer_pkg::NUM_BANKS];
   logic [2:0] bank;
   logic condPass;
   logic [31:0] operand;
   logic [31:0] byteMask;
   logic [31:0] next_current;
   logic [31:0] savedValue;
   logic isUser;
   logic longWrite;
   logic accept;
   operand_if opBus ();

   assign opBus.useImm = useImm;
   assign opBus.imm8 = imm8;
   assign opBus.rotate = rotate;
   assign opBus.regValue = sourceRegValue;
   assign operand = opBus.operand;

   operand_former former (
      .op(opBus.former)
   );

   always_comb begin
      logic n;
      logic z;
      logic c;
      logic v;
      n = current_status_word[31];
      z = current_status_word[30];
      c = current_status_word[29];
      v = current_status_word[28];
      case (instCond)
         status_xfer_pkg::COND_EQ: condPass = z;
         status_xfer_pkg::COND_NE: condPass = !z;
         status_xfer_pkg::COND_CS: condPass = c;
         status_xfer_pkg::COND_CC: condPass = !c;
         status_xfer_pkg::COND_MI: condPass = n;
         status_xfer_pkg::COND_PL: condPass = !n;
         status_xfer_pkg::COND_VS: condPass = v;
         status_xfer_pkg::COND_VC: condPass = !v;
         status_xfer_pkg::COND_HI: condPass = c && !z;
         status_xfer_pkg::COND_LS: condPass = !c || z;
         status_xfer_pkg::COND_GE: condPass = n == v;
         status_xfer_pkg::COND_LT: condPass = n != v;
         status_xfer_pkg::COND_GT: condPass = !z && (n == v);
         status_xfer_pkg::COND_LE: condPass = z || (n != v);
         status_xfer_pkg::COND_AL: condPass = 1'b1;
         default: condPass = 1'b0;
      endcase
   end

   // Bank follows the live mode, so a mode change takes effect on the next instruction.
   always_comb begin
      case (current_status_word[status_xfer_pkg::MODE_HI:status_xfer_pkg::MODE_LO])
         status_xfer_pkg::MODE_FIQ: bank = status_xfer_pkg::BANK_FIQ;
         status_xfer_pkg::MODE_IRQ: bank = status_xfer_pkg::BANK_IRQ;
         status_xfer_pkg::MODE_SVC: bank = status_xfer_pkg::BANK_SVC;
         status_xfer_pkg::MODE_ABORT: bank = status_xfer_pkg::BANK_ABORT;
         status_xfer_pkg::MODE_UNDEF: bank = status_xfer_pkg::BANK_UNDEF;
         default: bank = status_xfer_pkg::BANK_NONE;
      endcase
   end

   always_comb begin
      isUser = current_status_word[4:0] == status_xfer_pkg::MODE_USER;
      byteMask = 32'h00000000;
      if (fieldMask[status_xfer_pkg::FMASK_FLAGS]) begin
         byteMask = byteMask | status_xfer_pkg::FLAG_BYTE_MASK;
      end
      if (fieldMask[status_xfer_pkg::FMASK_STATUS]) begin
         byteMask = byteMask | status_xfer_pkg::STATUS_BYTE_MASK;
      end
      if (fieldMask[status_xfer_pkg::FMASK_EXT]) begin
         byteMask = byteMask | status_xfer_pkg::EXT_BYTE_MASK;
      end
      // User mode silently drops everything but the flags byte, with no exception.
      if (fieldMask[status_xfer_pkg::FMASK_CTRL] && !isUser) begin
         byteMask = byteMask | status_xfer_pkg::CTRL_BYTE_MASK;
      end
      if (isUser) begin
         byteMask = byteMask & status_xfer_pkg::FLAG_BYTE_MASK;
      end
      // Unimplemented bits, including 27 to 24, are accepted and discarded.
      next_current = ((current_status_word & ~byteMask) | (operand & byteMask))
         & status_xfer_pkg::DEFINED_MASK;
      savedValue = (bank == status_xfer_pkg::BANK_NONE) ? 32'h00000000 : savedBank[bank];
      longWrite = !useSaved && (fieldMask[2:0] != 3'h0);
      accept = instValid && state == IDLE;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         current_status_word <= status_xfer_pkg::CURRENT_RESET;
      end else if (accept && condPass && isWrite && !useSaved) begin
         current_status_word <= next_current;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < status_xfer_pkg::NUM_BANKS; gi++) begin : gSaved
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               savedBank[gi] <= status_xfer_pkg::SAVED_RESET;
            end else if (accept && condPass && isWrite && useSaved
               && bank == 3'(gi)) begin
               savedBank[gi] <= ((savedBank[gi] & ~byteMask) | (operand & byteMask))
                  & status_xfer_pkg::DEFINED_MASK;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= IDLE;
         waitCount <= 2'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            IDLE: begin
               if (accept) begin
                  if (condPass && isWrite && longWrite) begin
                     state <= WAIT_LONG;
                     waitCount <= status_xfer_pkg::WRITE_LONG_CYCLES - 2'h1;
                     busy <= 1'b1;
                  end else begin
                     done <= 1'b1;
                  end
               end
            end
            WAIT_LONG: begin
               waitCount <= waitCount - 2'h1;
               if (waitCount == 2'h1) begin
                  state <= IDLE;
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
            default: state <= IDLE;
         endcase
      end
   end

   // The program counter is never a legal destination, so no guard is spent on it.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         destWrite <= 1'b0;
         destIndex <= 4'h0;
         destData <= 32'h00000000;
      end else begin
         destWrite <= accept && condPass && !isWrite;
         if (accept && !isWrite) begin
            destIndex <= regIndex;
            destData <= useSaved ? savedValue : current_status_word;
         end
      end
   end

   assign currentStatus = current_status_word;
   assign processorMode = current_status_word[4:0];
endmodule : status_register_transfer
`default_nettype wire

// ### hw/status_xfer_pkg.sv
// Constants shared by the status-word transfer unit and its testbench.
// Assumes a 25 MHz core clock and a decode stage that presents one instruction at a time.
`default_nettype none
package status_xfer_pkg;
   localparam int WORD_W = 32;
   localparam int FLAG_HI = 31;
   localparam int FLAG_LO = 28;
   localparam int RSVFLAG_HI = 27;
   localparam int RSVFLAG_LO = 24;
   localparam int IRQ_DIS_BIT = 7;
   localparam int FIQ_DIS_BIT = 6;
   localparam int MODE_HI = 4;
   localparam int MODE_LO = 0;
   // Implemented bits: flags, two interrupt disables and the mode field.
   localparam logic [31:0] DEFINED_MASK = 32'hF00000DF;
   localparam logic [31:0] FLAG_BYTE_MASK = 32'hFF000000;
   localparam logic [31:0] STATUS_BYTE_MASK = 32'h00FF0000;
   localparam logic [31:0] EXT_BYTE_MASK = 32'h0000FF00;
   localparam logic [31:0] CTRL_BYTE_MASK = 32'h000000FF;
   localparam int FMASK_CTRL = 0;
   localparam int FMASK_EXT = 1;
   localparam int FMASK_STATUS = 2;
   localparam int FMASK_FLAGS = 3;
   localparam logic [4:0] MODE_USER = 5'h10;
   localparam logic [4:0] MODE_FIQ = 5'h11;
   localparam logic [4:0] MODE_IRQ = 5'h12;
   localparam logic [4:0] MODE_SVC = 5'h13;
   localparam logic [4:0] MODE_ABORT = 5'h17;
   localparam logic [4:0] MODE_UNDEF = 5'h1B;
   localparam logic [4:0] MODE_SYSTEM = 5'h1F;
   localparam logic [4:0] MODE_FIELD_MASK = 5'h1F;
   // Reset enters supervisor mode with both interrupt classes disabled.
   localparam logic [31:0] CURRENT_RESET = 32'h000000D3;
   localparam logic [31:0] SAVED_RESET = 32'h00000000;
   localparam int NUM_BANKS = 5;
   localparam logic [2:0] BANK_FIQ = 3'h0;
   localparam logic [2:0] BANK_IRQ = 3'h1;
   localparam logic [2:0] BANK_SVC = 3'h2;
   localparam logic [2:0] BANK_ABORT = 3'h3;
   localparam logic [2:0] BANK_UNDEF = 3'h4;
   localparam logic [2:0] BANK_NONE = 3'h7;
   localparam logic [1:0] READ_CYCLES = 2'h1;
   localparam logic [1:0] WRITE_SHORT_CYCLES = 2'h1;
   localparam logic [1:0] WRITE_LONG_CYCLES = 2'h3;
   localparam logic [3:0] COND_EQ = 4'h0;
   localparam logic [3:0] COND_NE = 4'h1;
   localparam logic [3:0] COND_CS = 4'h2;
   localparam logic [3:0] COND_CC = 4'h3;
   localparam logic [3:0] COND_MI = 4'h4;
   localparam logic [3:0] COND_PL = 4'h5;
   localparam logic [3:0] COND_VS = 4'h6;
   localparam logic [3:0] COND_VC = 4'h7;
   localparam logic [3:0] COND_HI = 4'h8;
   localparam logic [3:0] COND_LS = 4'h9;
   localparam logic [3:0] COND_GE = 4'hA;
   localparam logic [3:0] COND_LT = 4'hB;
   localparam logic [3:0] COND_GT = 4'hC;
   localparam logic [3:0] COND_LE = 4'hD;
   localparam logic [3:0] COND_AL = 4'hE;
   localparam logic [3:0] PROG_COUNTER_INDEX = 4'hF;
endpackage : status_xfer_pkg
`default_nettype wire

// ### tb/status_register_transfer_tb.sv
// Self-checking bench for the status-word transfer unit with a reference model.
// Assumes status updates at the taking edge and reads finish one cycle later.
`default_nettype none
module status_register_transfer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, instValid, isWrite, useSaved, useImm, busy, done, destWrite;
   logic [3:0] instCond, fieldMask, rotate, regIndex, destIndex;
   logic [7:0] imm8;
   logic [31:0] sourceRegValue, destData, currentStatus, expCur;
   logic [4:0] processorMode;
   logic [31:0] expSav [5];
   logic [4:0] modes [7] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F};
   int n_errors = 0;
   int num_checks = 0;
   int seed = 32'h9F45E926;
   status_register_transfer status_register_transfer_inst (.clk, .rst_b, .instValid,
      .instCond, .isWrite, .useSaved, .fieldMask, .useImm, .imm8, .rotate, .regIndex,
      .sourceRegValue, .busy, .done, .destWrite, .destIndex, .destData, .currentStatus,
      .processorMode);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [2:0] bankOf(input logic [4:0] m);
      case (m)
         5'h11: return 3'h0;
         5'h12: return 3'h1;
         5'h13: return 3'h2;
         5'h17: return 3'h3;
         5'h1B: return 3'h4;
         default: return 3'h7;
      endcase
   endfunction : bankOf
   function automatic logic passes(input logic [3:0] c, input logic [3:0] f);
      logic n, z, cf, v, r;
      {n, z, cf, v} = f;
      case (c[3:1])
         3'h0: r = z;
         3'h1: r = cf;
         3'h2: r = n;
         3'h3: r = v;
         3'h4: r = cf && !z;
         3'h5: r = n == v;
         3'h6: r = !z && n == v;
         default: r = 1'b1;
      endcase
      return (c == 4'hF) ? 1'b0 : r ^ (c[0] && c != 4'hE);
   endfunction : passes
   function automatic logic [31:0] rot(input logic [7:0] i, input logic [3:0] r);
      logic [63:0] d;
      d = {24'h0, i, 24'h0, i};
      return 32'(d >> (2 * r));
   endfunction : rot
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : cmp
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   task automatic do_reset;
      instValid <= 1'b0;
      rst_b <= 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      expCur = status_xfer_pkg::CURRENT_RESET;
      foreach (expSav[i]) expSav[i] = 32'h0;
      @(posedge clk);
      cmp("status", expCur, currentStatus);
   endtask : do_reset
   // Called at a rising edge; outputs are read at later rising edges, before that
   // edge's own updates land, so each value seen is the one the previous edge launched.
   task automatic issue(input logic w, s, input logic [3:0] m, c, input logic im,
         input logic [7:0] i8, input logic [3:0] r, input logic [31:0] val);
      logic [31:0] op, mk, old;
      logic [3:0] ri;
      logic [2:0] b;
      logic p;
      int lat, n;
      b = bankOf(expCur[4:0]);
      p = passes(c, expCur[31:28]);
      old = s ? ((b == 3'h7) ? 32'h0 : expSav[b]) : expCur;
      op = im ? rot(i8, r) : val;
      mk = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
      if (!s && expCur[4:0] == 5'h10) mk = mk & 32'hFF000000;
      lat = (w && !s && m[2:0] != 3'h0 && p) ? 3 : 1;
      {instValid, isWrite, useSaved, useImm} <= {1'b1, w, s, im};
      {fieldMask, instCond, imm8, rotate, sourceRegValue} <= {m, c, i8, r, val};
      ri = 4'({$random(seed)} % 15);
      regIndex <= ri;
      if (p && w) begin
         op = ((old & ~mk) | (op & mk)) & status_xfer_pkg::DEFINED_MASK;
         if (!s) expCur = op;
         else if (b != 3'h7) expSav[b] = op;
      end
      // The first edge takes the request; a long write keeps it presented while busy,
      // which the unit must ignore, and it is withdrawn one edge before completion.
      @(posedge clk);
      n = 0;
      do begin
         if (n == lat - 1) instValid <= 1'b0;
         @(posedge clk);
         n++;
      end while (!done && n < 6);
      if (!done) begin
         n_errors++;
         end_sim();
      end
      cmp("latency", 32'(lat), 32'(n));
      cmp("destWrite", 32'(p && !w), 32'(destWrite));
      if (!w) cmp("destIndex", 32'(ri), 32'(destIndex));
      if (!w && p) cmp("destData", old, destData);
      cmp("status", expCur, currentStatus);
      cmp("mode", 32'(expCur[4:0]), 32'(processorMode));
   endtask : issue
   task automatic rnd;
      logic [31:0] v;
      logic [3:0] m;
      logic s, im;
      v = $random(seed);
      m = 4'($random(seed));
      s = bankOf(expCur[4:0]) != 3'h7 && v[8];
      im = v[9] && (s || !m[0]);
      if (!s && m[0]) v[4:0] = modes[{$random(seed)} % 7];
      issue(v[10], s, m, v[11] ? 4'hE : v[15:12], im, v[23:16], v[7:4], v);
   endtask : rnd
   initial begin
      rst_b = 1'b0;
      {instValid, isWrite, useSaved, useImm} = 4'h0;
      {instCond, fieldMask, rotate, regIndex, imm8, sourceRegValue} = 56'h0;
      for (int k = 0; k < 4; k++) begin
         do_reset();
         issue(1'b1, 1'b0, 4'h8, 4'hE, 1'b1, 8'hA0, 4'h4, 32'h0);
         issue(1'b1, 1'b0, 4'hF, 4'hE, 1'b0, 8'h0, 4'h0, 32'h5F0000D1);
         for (int j = 0; j < 50; j++) rnd();
      end
      instValid <= 1'b0;
      repeat (2) @(posedge clk);
      end_sim();
   end
endmodule : status_register_transfer_tb
bind status_register_transfer status_xfer_assertions status_xfer_assertions_inst (.clk,
   .rst_b, .instValid, .instCond, .isWrite, .useSaved, .fieldMask, .useImm, .regIndex,
   .sourceRegValue, .busy, .done, .destWrite, .destIndex, .destData, .currentStatus,
   .processorMode);
`default_nettype wire

// ### tb/status_xfer_assertions.sv
// Port-level checks for the status-word transfer unit.
// Assumes it is bound into the unit and sees its ports.
`default_nettype none
module status_xfer_assertions (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic instValid,
   input wire logic [3:0] instCond,
   input wire logic isWrite,
   input wire logic useSaved,
   input wire logic [3:0] fieldMask,
   input wire logic useImm,
   input wire logic [3:0] regIndex,
   input wire logic [31:0] sourceRegValue,
   input wire logic busy,
   input wire logic done,
   input wire logic destWrite,
   input wire logic [3:0] destIndex,
   input wire logic [31:0] destData,
   input wire logic [31:0] currentStatus,
   input wire logic [4:0] processorMode
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic take;
   logic wCur;
   assign take = instValid && !busy && instCond == 4'hE;
   assign wCur = take && isWrite && !useSaved;
   chk_read_latency: assert property (take && !isWrite |=> done && destWrite)
      else $error("read not finished in one cycle");
   chk_read_data: assert property (take && !isWrite && !useSaved |=>
      destData == $past(currentStatus) && destIndex == $past(regIndex))
      else $error("read data wrong");
   chk_long_write: assert property (wCur && fieldMask[2:0] != 3'h0 |=>
      busy [*2] ##1 (done && !busy))
      else $error("long write timing wrong");
   chk_short_write: assert property (take && isWrite &&
      (useSaved || fieldMask[2:0] == 3'h0) |=> done && !busy)
      else $error("short write timing wrong");
   chk_never_cond: assert property (instValid && !busy && instCond == 4'hF |=>
      done && !destWrite && $stable(currentStatus))
      else $error("failed condition had an effect");
   chk_reserved_zero: assert property ((currentStatus & ~32'hF00000DF) == 32'h0)
      else $error("reserved status bit set");
   chk_user_ctrl: assert property (wCur && processorMode == 5'h10 |=>
      currentStatus[7:0] == $past(currentStatus[7:0]))
      else $error("user write changed control bits");
   chk_mode_write: assert property (wCur && !useImm && fieldMask[0] &&
      processorMode != 5'h10 |=> processorMode == $past(sourceRegValue[4:0]))
      else $error("mode write not applied");
   chk_flag_write: assert property (wCur && !useImm && fieldMask[3] |=>
      currentStatus[31:28] == $past(sourceRegValue[31:28]))
      else $error("flag write not applied");
endmodule : status_xfer_assertions
`default_nettype wire
